// ### rtl/close_onto_fault.sv
/*
 close-onto-fault arming timer with wishbone register slave, event flags,
 counters and a twelve-entry record log.
 assumes arm, inhibit and trip-source inputs arrive asynchronously from
 pins or foreign logic; one 25 MHz clock, synchronous active-high reset.
*/
// The implementer's own choices: the placing of the registers and register access over Wishbone.
// Function
// - arm only on rising edge of arm input
// - window lasts configured length, default one second
// - trip at once on function input in window
// - trip condition is OR of function inputs
// - any arm source treated alike as edge
// - inhibit prevents window start, not a trip in an open window
// - decisions use binary inputs only
// - five operating modes, reset mode on
// - status force overrides reported condition
// - report normal, init, active, trip, blocked
// - ON/OFF events, selectable storage
// - each stored event is stamped; only the latest stored event is kept, with its time
// - clearable counters for init, blocked, active, trip
// - twelve-entry circular log on window start
// - log holds group, remaining and elapsed time
// - group change applies live to window
`timescale 1ns/1ps
`default_nettype none

module close_onto_fault #(
   parameter int TICK_CYCLES = close_onto_fault_pkg::TICK_CYC
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // binary inputs
   input  wire logic        arm_request_in_i,
   input  wire logic        inhibit_in_i,
   input  wire logic [close_onto_fault_pkg::FN_W-1:0] trip_source_in_i,
   // outputs
   output logic             window_open_out_o,
   output logic             instant_trip_out_o,
   output logic             irq_o
);

   localparam int FN_W = close_onto_fault_pkg::FN_W;
   localparam int NGRP = close_onto_fault_pkg::NGRP;
   localparam int LN   = close_onto_fault_pkg::LOG_N;
   localparam int TW   = close_onto_fault_pkg::TW;
   localparam int F_MODE  = close_onto_fault_pkg::F_MODE;
   localparam int F_FORCE = close_onto_fault_pkg::F_FORCE;
   localparam int F_EVSEL = close_onto_fault_pkg::F_EVSEL;
   localparam int C_INIT  = close_onto_fault_pkg::C_INIT;
   localparam int C_BLK   = close_onto_fault_pkg::C_BLK;
   localparam int C_ACT   = close_onto_fault_pkg::C_ACT;
   localparam int C_TRP   = close_onto_fault_pkg::C_TRP;

   typedef struct packed {
      logic                                ack;
      logic [31:0]                         rdat;
      close_onto_fault_pkg::mode_t         mode;
      close_onto_fault_pkg::force_t        frc;
      logic [1:0]                          evsel;
      logic [2:0]                          grp;
      logic [NGRP-1:0][TW-1:0]             wlen;
      logic [31:0]                         tick;
      logic [31:0]                         now;
      logic                                a1;
      logic                                a2;
      logic                                ap;
      logic                                i1;
      logic                                i2;
      logic [FN_W-1:0]                     f1;
      logic [FN_W-1:0]                     f2;
      close_onto_fault_pkg::wstate_t       st;
      logic [31:0]                         wsub;
      logic [TW-1:0]                       ela;
      logic [3:0]                          lv;
      logic [7:0]                          sts;
      logic [7:0]                          msk;
      logic [2:0]                          lcode;
      logic [31:0]                         ltime;
      logic [3:0][31:0]                    cnt;
      close_onto_fault_pkg::log_t [LN-1:0] lg;
      logic [3:0]                          head;
      logic [3:0]                          fill;
      logic [3:0]                          lsel;
      logic                                irq;
      logic                                trip;
      logic                                open;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic                        req;
   logic                        wr;
   logic [31:0]                 wm;
   logic [31:0]                 wv;
   logic                        ms_tick;
   logic                        en;
   logic                        blk;
   logic                        tst;
   logic                        rise;
   logic                        anyfn;
   logic                        start;
   logic                        expire;
   logic [TW-1:0]               len;
   logic [TW-1:0]               rem;
   logic [3:0]                  lvl;
   logic [3:0]                  on_e;
   logic [3:0]                  off_e;
   logic [7:0]                  ev;
   logic [3:0]                  clr;
   close_onto_fault_pkg::cond_t cond;
   close_onto_fault_pkg::cond_t shown;
   close_onto_fault_pkg::log_t  lsel_e;

   always_comb begin
      s_d = s_q;

      // bus decode; writes land on the edge that raises ack
      req = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wr  = req & wb_we_i;
      wm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wv  = wb_dat_i & wm;

      // millisecond time base for stamps; the window timer keeps its own sub-count
      ms_tick   = (s_q.tick == 32'(TICK_CYCLES - 1));
      s_d.tick  = ms_tick ? 32'h0 : s_q.tick + 32'h1;
      s_d.now   = s_q.now + {31'h0, ms_tick};

      // two-flop synchronisers; only the second stage is used
      s_d.a1 = arm_request_in_i;
      s_d.a2 = s_q.a1;
      s_d.ap = s_q.a2;
      s_d.i1 = inhibit_in_i;
      s_d.i2 = s_q.i1;
      s_d.f1 = trip_source_in_i;
      s_d.f2 = s_q.f1;

      en  = (s_q.mode != close_onto_fault_pkg::M_OFF);
      tst = (s_q.mode == close_onto_fault_pkg::M_TEST) ||
            (s_q.mode == close_onto_fault_pkg::M_TEST_BLK);
      blk = en & (s_q.i2 ||
            (s_q.mode == close_onto_fault_pkg::M_BLOCKED) ||
            (s_q.mode == close_onto_fault_pkg::M_TEST_BLK));

      rise  = s_q.a2 & ~s_q.ap;
      anyfn = |s_q.f2;
      start = rise & en & ~blk;

      len    = s_q.wlen[s_q.grp];
      expire = (s_q.st != close_onto_fault_pkg::W_IDLE) &&
               (s_q.ela >= len);
      rem    = (s_q.ela < len) ? len - s_q.ela : '0;

      // window timer counts in whole milliseconds from the arming edge
      if (s_q.st != close_onto_fault_pkg::W_IDLE) begin
         if (s_q.wsub == 32'(TICK_CYCLES - 1)) begin
            s_d.wsub = 32'h0;
            if (s_q.ela != '1)
               s_d.ela = s_q.ela + 21'h1;
         end else begin
            s_d.wsub = s_q.wsub + 32'h1;
         end
      end

      // record the window as it stood just before the new start
      lsel_e.stamp = s_q.now;
      lsel_e.grp   = s_q.grp;
      lsel_e.rem   = (s_q.st == close_onto_fault_pkg::W_IDLE) ? len : rem;
      lsel_e.ela   = (s_q.st == close_onto_fault_pkg::W_IDLE) ? '0 : s_q.ela;

      if (!en) begin
         s_d.st = close_onto_fault_pkg::W_IDLE;
      end else if (start) begin
         s_d.st   = close_onto_fault_pkg::W_ARMED;
         s_d.ela  = '0;
         s_d.wsub = 32'h0;
         s_d.lg[s_q.head] = lsel_e;
         s_d.head = (s_q.head == 4'(LN - 1)) ? 4'h0 : s_q.head + 4'h1;
         if (s_q.fill != 4'(LN))
            s_d.fill = s_q.fill + 4'h1;
      end else if (expire) begin
         s_d.st = close_onto_fault_pkg::W_IDLE;
      end else begin
         case (s_q.st)
            close_onto_fault_pkg::W_ARMED: begin
               if (anyfn)
                  s_d.st = close_onto_fault_pkg::W_TRIPPED;
            end
            close_onto_fault_pkg::W_TRIPPED: begin
               if (!anyfn)
                  s_d.st = close_onto_fault_pkg::W_ARMED;
            end
            default: s_d.st = close_onto_fault_pkg::W_IDLE;
         endcase
      end

      // test modes run the logic but keep it off the window and trip outputs
      s_d.open = (s_d.st != close_onto_fault_pkg::W_IDLE) & ~tst;
      s_d.trip = (s_d.st == close_onto_fault_pkg::W_TRIPPED) & ~tst;

      // condition flags and their ON/OFF edges
      lvl[C_INIT] = en & s_q.a2;
      lvl[C_BLK]  = blk;
      lvl[C_ACT]  = (s_q.st != close_onto_fault_pkg::W_IDLE);
      lvl[C_TRP]  = (s_q.st == close_onto_fault_pkg::W_TRIPPED);
      s_d.lv = lvl;
      on_e   = lvl & ~s_q.lv;
      off_e  = ~lvl & s_q.lv;
      for (int k = 0; k < 4; k++) begin
         ev[2*k]   = on_e[k] & s_q.evsel[0];
         ev[2*k+1] = off_e[k] & s_q.evsel[1];
      end

      // latest stored event, highest bit wins within one cycle
      for (int k = 0; k < 8; k++) begin
         if (ev[k]) begin
            s_d.lcode = 3'(k);
            s_d.ltime = s_q.now;
         end
      end

      if (lvl[C_BLK])
         cond = close_onto_fault_pkg::S_BLOCKED;
      else if (lvl[C_TRP])
         cond = close_onto_fault_pkg::S_TRIP;
      else if (lvl[C_ACT])
         cond = close_onto_fault_pkg::S_ACTIVE;
      else if (lvl[C_INIT])
         cond = close_onto_fault_pkg::S_INIT;
      else
         cond = close_onto_fault_pkg::S_NORMAL;
      case (s_q.frc)
         close_onto_fault_pkg::F_BLOCKED:
            shown = close_onto_fault_pkg::S_BLOCKED;
         close_onto_fault_pkg::F_ACTIVE:
            shown = close_onto_fault_pkg::S_ACTIVE;
         close_onto_fault_pkg::F_TRIP:
            shown = close_onto_fault_pkg::S_TRIP;
         default: shown = cond;
      endcase

      // register writes
      clr = '0;
      if (wr) begin
         if (wb_adr_i[7] && wb_adr_i[6:5] == 2'h0) begin
            s_d.wlen[wb_adr_i[4:2]] =
               ((s_q.wlen[wb_adr_i[4:2]] & ~wm[TW-1:0]) | wv[TW-1:0]) >
               close_onto_fault_pkg::WLEN_MAX ?
               close_onto_fault_pkg::WLEN_MAX :
               (s_q.wlen[wb_adr_i[4:2]] & ~wm[TW-1:0]) | wv[TW-1:0];
         end else begin
            case (wb_adr_i)
               close_onto_fault_pkg::A_CTRL: begin
                  if (wb_sel_i[0] && wb_dat_i[F_MODE+:3] <= 3'h4)
                     s_d.mode = close_onto_fault_pkg::mode_t'(
                        wb_dat_i[F_MODE+:3]);
                  if (wb_sel_i[0])
                     s_d.frc = close_onto_fault_pkg::force_t'(
                        wb_dat_i[F_FORCE+:2]);
                  if (wb_sel_i[1])
                     s_d.evsel = wb_dat_i[F_EVSEL+:2];
               end
               close_onto_fault_pkg::A_GROUP: begin
                  if (wb_sel_i[0])
                     s_d.grp = wb_dat_i[2:0];
               end
               close_onto_fault_pkg::A_EV_MSK: begin
                  if (wb_sel_i[0])
                     s_d.msk = wb_dat_i[7:0];
               end
               close_onto_fault_pkg::A_TIME: begin
                  s_d.now = (s_q.now & ~wm) | wv;
               end
               close_onto_fault_pkg::A_CNT_CLR: begin
                  clr = wv[3:0];
               end
               close_onto_fault_pkg::A_LOG_SEL: begin
                  if (wb_sel_i[0])
                     s_d.lsel = wb_dat_i[3:0];
               end
               default: ;
            endcase
         end
      end

      // counters: a clear in the same cycle as an ON still counts it
      for (int k = 0; k < 4; k++)
         s_d.cnt[k] = (clr[k] ? 32'h0 : s_q.cnt[k]) +
                      {31'h0, on_e[k]};

      // sticky flags: a new event wins over a write-one clear
      if (wr && wb_adr_i == close_onto_fault_pkg::A_EV_STS)
         s_d.sts = (s_q.sts & ~wv[7:0]) | ev;
      else
         s_d.sts = s_q.sts | ev;
      s_d.irq = |(s_d.sts & s_d.msk);

      // read data, unmapped offsets read zero
      s_d.ack = req;
      if (req) begin
         s_d.rdat = 32'h0;
         if (s_q.lsel < 4'(LN))
            lsel_e = s_q.lg[s_q.lsel];
         else
            lsel_e = '0;
         if (wb_adr_i[7] && wb_adr_i[6:5] == 2'h0) begin
            s_d.rdat[TW-1:0] = s_q.wlen[wb_adr_i[4:2]];
         end else begin
            case (wb_adr_i)
               close_onto_fault_pkg::A_CTRL: begin
                  s_d.rdat[F_MODE+:3]  = s_q.mode;
                  s_d.rdat[F_FORCE+:2] = s_q.frc;
                  s_d.rdat[F_EVSEL+:2] = s_q.evsel;
               end
               close_onto_fault_pkg::A_GROUP:
                  s_d.rdat[2:0] = s_q.grp;
               close_onto_fault_pkg::A_STATUS:
                  s_d.rdat[6:0] = {s_q.trip, s_q.open, s_q.i2, s_q.a2,
                                   shown};
               close_onto_fault_pkg::A_EV_STS:
                  s_d.rdat[7:0] = s_q.sts;
               close_onto_fault_pkg::A_EV_MSK:
                  s_d.rdat[7:0] = s_q.msk;
               close_onto_fault_pkg::A_TIME:
                  s_d.rdat = s_q.now;
               close_onto_fault_pkg::A_LAST:
                  s_d.rdat[2:0] = s_q.lcode;
               close_onto_fault_pkg::A_LAST_T:
                  s_d.rdat = s_q.ltime;
               close_onto_fault_pkg::A_LOG_SEL:
                  s_d.rdat[3:0] = s_q.lsel;
               close_onto_fault_pkg::A_LOG_T:
                  s_d.rdat = lsel_e.stamp;
               close_onto_fault_pkg::A_LOG_REM:
                  s_d.rdat = {lsel_e.grp, 8'h0, lsel_e.rem};
               close_onto_fault_pkg::A_LOG_ELA:
                  s_d.rdat[TW-1:0] = lsel_e.ela;
               close_onto_fault_pkg::A_LOG_HEAD:
                  s_d.rdat[7:0] = {s_q.fill, s_q.head};
               close_onto_fault_pkg::A_WIN_REM:
                  s_d.rdat[TW-1:0] =
                     (s_q.st == close_onto_fault_pkg::W_IDLE) ? '0 : rem;
               default: begin
                  if (wb_adr_i >= close_onto_fault_pkg::A_CNT0 &&
                      wb_adr_i < close_onto_fault_pkg::A_LOG_SEL)
                     s_d.rdat = s_q.cnt[wb_adr_i[3:2] - 2'h1];
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.evsel <= close_onto_fault_pkg::EVSEL_RST;
         s_q.wlen  <= {NGRP{close_onto_fault_pkg::WLEN_RST}};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o           = s_q.rdat;
   assign wb_ack_o           = s_q.ack;
   assign window_open_out_o  = s_q.open;
   assign instant_trip_out_o = s_q.trip;
   assign irq_o              = s_q.irq;

endmodule

`default_nettype wire

// ### rtl/close_onto_fault_pkg.sv
/*
 close-onto-fault arming timer: register map, field layout, reset values,
 time constants and state encodings.
 assumes a 25 MHz system clock and a 32-bit classic wishbone register bus.
*/
package close_onto_fault_pkg;

   // widths
   localparam int FN_W  = 8;
   localparam int NGRP  = 8;
   localparam int LOG_N = 12;
   localparam int TW    = 21;

   // time base: window lengths and timestamps count milliseconds
   localparam int CLK_NS   = 40;
   localparam int MS_NS    = 1000000;
   localparam int TICK_CYC = MS_NS / CLK_NS;

   localparam logic [TW-1:0] WLEN_RST = 21'h0003e8;
   localparam logic [TW-1:0] WLEN_MAX = 21'h1b7740;
   localparam logic [1:0]    EVSEL_RST = 2'h3;

   // register byte offsets
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_GROUP    = 8'h04;
   localparam logic [7:0] A_STATUS   = 8'h08;
   localparam logic [7:0] A_EV_STS   = 8'h0c;
   localparam logic [7:0] A_EV_MSK   = 8'h10;
   localparam logic [7:0] A_TIME     = 8'h14;
   localparam logic [7:0] A_LAST     = 8'h18;
   localparam logic [7:0] A_LAST_T   = 8'h1c;
   localparam logic [7:0] A_CNT_CLR  = 8'h20;
   localparam logic [7:0] A_CNT0     = 8'h24;
   localparam logic [7:0] A_LOG_SEL  = 8'h34;
   localparam logic [7:0] A_LOG_T    = 8'h38;
   localparam logic [7:0] A_LOG_REM  = 8'h3c;
   localparam logic [7:0] A_LOG_ELA  = 8'h40;
   localparam logic [7:0] A_LOG_HEAD = 8'h44;
   localparam logic [7:0] A_WIN_REM  = 8'h48;
   localparam logic [7:0] A_WLEN0    = 8'h80;

   // control register fields
   localparam int F_MODE  = 0;
   localparam int F_FORCE = 4;
   localparam int F_EVSEL = 8;

   // condition flags; event bit 2k is the ON, 2k+1 the OFF of flag k
   localparam int C_INIT = 0;
   localparam int C_BLK  = 1;
   localparam int C_ACT  = 2;
   localparam int C_TRP  = 3;

   typedef enum logic [2:0] {
      M_ON = 3'h0, M_BLOCKED = 3'h1, M_TEST = 3'h2,
      M_TEST_BLK = 3'h3, M_OFF = 3'h4
   } mode_t;

   typedef enum logic [1:0] {
      F_NORMAL = 2'h0, F_BLOCKED = 2'h1, F_ACTIVE = 2'h2, F_TRIP = 2'h3
   } force_t;

   typedef enum logic [2:0] {
      S_NORMAL = 3'h0, S_INIT = 3'h1, S_ACTIVE = 3'h2,
      S_TRIP = 3'h3, S_BLOCKED = 3'h4
   } cond_t;

   typedef enum logic [1:0] {
      W_IDLE = 2'b00, W_ARMED = 2'b01, W_TRIPPED = 2'b11
   } wstate_t;

   typedef struct packed {
      logic [31:0]   stamp;
      logic [2:0]    grp;
      logic [TW-1:0] rem;
      logic [TW-1:0] ela;
   } log_t;

endpackage

// ### dv/close_onto_fault_properties.sv
/* checker: bus answer, arming, blocking and trip timing at the ports.
   assumes the bench holds arm low through reset and idles between tests. */
`timescale 1ns/1ps
`default_nettype none
module close_onto_fault_properties #(
   parameter int TICK_CYCLES = 25000
) (
   // clock, reset, enable
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins
   input wire logic        arm_request_in_i,
   input wire logic        inhibit_in_i,
   input wire logic [7:0]  trip_source_in_i,
   input wire logic        window_open_out_o,
   input wire logic        instant_trip_out_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence arm_rose;
      !$past(arm_request_in_i, 4) && $past(arm_request_in_i, 3);
   endsequence
   sequence src_held;
      (window_open_out_o && (|trip_source_in_i))[*6];
   endsequence
   bus_answer_a: assert property (bus_req |=> wb_ack_o)
      else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   arm_edge_a: assert property ($rose(window_open_out_o) |-> arm_rose)
      else $error("window opened without arming edge");
   inhibit_hold_a: assert property (
      $past(inhibit_in_i, 2) && $past(inhibit_in_i, 3) &&
      $past(inhibit_in_i, 4) && $past(inhibit_in_i, 5)
      |-> !$rose(window_open_out_o))
      else $error("window opened while inhibited");
   trip_prompt_a: assert property (src_held |-> instant_trip_out_o)
      else $error("no trip on source in window");
   trip_window_a: assert property ($rose(instant_trip_out_o) |->
      $past(window_open_out_o) || $past(window_open_out_o, 2) ||
      $past(window_open_out_o, 3))
      else $error("trip outside window");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
      !wb_ack_o && !window_open_out_o && !instant_trip_out_o && !irq_o)
      else $error("output active after reset");
   cover property ($fell(window_open_out_o));
endmodule
bind close_onto_fault close_onto_fault_properties #(
   .TICK_CYCLES(TICK_CYCLES)
) u_props (.*);
`default_nettype wire

// ### dv/close_source_model.sv
/* far side: breaker close command, digital input, block and start lines.
   assumes bench requests change just after the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module close_source_model (
   // requests
   input  wire logic       clk_i,
   input  wire logic       close_i,
   input  wire logic       slow_i,
   input  wire logic       di_i,
   input  wire logic       block_i,
   input  wire logic [7:0] fault_i,
   // lines into the block
   output logic            arm_o,
   output logic            block_o,
   output logic [7:0]      start_o
);
   logic [3:0] hold_q;
   initial begin
      hold_q = 4'h0;
      arm_o = 1'b0;
      block_o = 1'b0;
      start_o = 8'h00;
   end
   // a slow breaker keeps its close contact made longer
   always @(posedge clk_i) begin
      if (close_i) hold_q <= slow_i ? 4'h8 : 4'h3;
      else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
      arm_o   <= di_i | close_i | (hold_q != 4'h0);
      block_o <= block_i;
      start_o <= fault_i;
   end
endmodule
`default_nettype wire

// ### dv/close_onto_fault_tb.sv
/* bench: register access, arming, expiry, restart, trip, modes, events.
   assumes the block and close_source_model; one 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module close_onto_fault_tb;
   localparam int TK = 10;
   localparam int WIN = 3 * TK + 1;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cls = 1'b0, slow = 1'b0;
   logic di = 1'b0, inh = 1'b0;
   logic [7:0] adr = 8'h00, flt = 8'h00, src;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, arm, blk, open_w, trip, irq;
   int fails = 0, checks_done = 0, n;
   always #20 clk_i = ~clk_i;
   close_source_model peer (.clk_i(clk_i), .close_i(cls), .slow_i(slow),
      .di_i(di), .block_i(inh), .fault_i(flt), .arm_o(arm),
      .block_o(blk), .start_o(src));
   close_onto_fault #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .arm_request_in_i(arm), .inhibit_in_i(blk),
      .trip_source_in_i(src), .window_open_out_o(open_w),
      .instant_trip_out_o(trip), .irq_o(irq));
   task automatic chk(input string s, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", s, e, g);
         fails++;
      end
   endtask
   task automatic wbx(input logic w, input logic [7:0] a, input int d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack", 1, n < 50);
   endtask
   task automatic pulse_arm();
      @(posedge clk_i);
      cls <= 1'b1;
      @(posedge clk_i);
      cls <= 1'b0;
   endtask
   task automatic wait_on(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin @(posedge clk_i); n++; end
      chk("wait", 1, n < lim);
   endtask
   task automatic check_at(input int c, input logic v);
      repeat (c) @(posedge clk_i);
      chk("open", v, open_w);
   endtask
   task automatic t_reset();
      wbx(0, close_onto_fault_pkg::A_CTRL, 0);
      chk("ctrl", 32'h300, q & 32'h3ff);
      wbx(0, close_onto_fault_pkg::A_WLEN0, 0);
      chk("wlen", 32'(close_onto_fault_pkg::WLEN_RST), q);
      wbx(0, close_onto_fault_pkg::A_STATUS, 0);
      chk("status", close_onto_fault_pkg::S_NORMAL, q[2:0]);
      wbx(0, 8'h60, 0);
      chk("unmapped", 0, q);
      wbx(1, 8'h88, 32'hffffffff);
      wbx(0, 8'h88, 0);
      chk("clamp", 32'(close_onto_fault_pkg::WLEN_MAX), q);
   endtask
   task automatic t_window();
      wbx(1, close_onto_fault_pkg::A_WLEN0, 3);
      pulse_arm();
      wait_on(open_w, 1'b1, 20);
      n = 0;
      while (open_w === 1'b1 && n < 200) begin @(posedge clk_i); n++; end
      chk("window", WIN, n);
      wbx(0, close_onto_fault_pkg::A_STATUS, 0);
      chk("idle", close_onto_fault_pkg::S_NORMAL, q[2:0]);
      wbx(0, close_onto_fault_pkg::A_EV_STS, 0);
      chk("act off", 1, q[2 * close_onto_fault_pkg::C_ACT + 1]);
   endtask
   task automatic t_level();
      di <= 1'b1;
      wait_on(open_w, 1'b1, 20);
      wait_on(open_w, 1'b0, 100);
      check_at(40, 1'b0);
      di <= 1'b0;
   endtask
   task automatic t_restart();
      pulse_arm();
      wait_on(open_w, 1'b1, 20);
      repeat (15) @(posedge clk_i);
      pulse_arm();
      check_at(30, 1'b1);
      check_at(15, 1'b0);
   endtask
   task automatic t_group();
      wbx(1, 8'h84, 6);
      pulse_arm();
      wait_on(open_w, 1'b1, 20);
      repeat (5) @(posedge clk_i);
      wbx(1, close_onto_fault_pkg::A_GROUP, 1);
      check_at(35, 1'b1);
      wait_on(open_w, 1'b0, 100);
      wbx(1, close_onto_fault_pkg::A_GROUP, 0);
   endtask
   task automatic t_trip();
      wbx(1, close_onto_fault_pkg::A_CNT_CLR, 32'hf);
      slow <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         pulse_arm();
         wait_on(open_w, 1'b1, 20);
         flt <= 8'h01 << i;
         wait_on(trip, 1'b1, 10);
         wbx(0, close_onto_fault_pkg::A_STATUS, 0);
         chk("trip st", close_onto_fault_pkg::S_TRIP, q[2:0]);
         flt <= 8'h00;
         wait_on(trip, 1'b0, 10);
         wait_on(open_w, 1'b0, 100);
      end
      slow <= 1'b0;
      wbx(0, 8'h30, 0);
      chk("trips", 8, q);
      wbx(1, close_onto_fault_pkg::A_CNT_CLR, 32'h8);
      wbx(0, 8'h30, 0);
      chk("cleared", 0, q);
   endtask
   task automatic t_block();
      inh <= 1'b1;
      repeat (4) @(posedge clk_i);
      pulse_arm();
      check_at(30, 1'b0);
      inh <= 1'b0;
   endtask
   task automatic t_modes();
      for (int m = 1; m < 5; m++) begin
         wbx(1, close_onto_fault_pkg::A_CTRL, 32'h300 | m);
         wbx(0, close_onto_fault_pkg::A_CTRL, 0);
         chk("mode", m, q[2:0]);
         pulse_arm();
         check_at(12, 1'b0);
         repeat (30) @(posedge clk_i);
      end
      wbx(1, close_onto_fault_pkg::A_CTRL, 32'h305);
      wbx(0, close_onto_fault_pkg::A_CTRL, 0);
      chk("bad mode", 32'h304, q & 32'h3ff);
      wbx(1, close_onto_fault_pkg::A_CTRL, 32'h300);
   endtask
   task automatic t_force();
      close_onto_fault_pkg::cond_t e [3];
      e = '{close_onto_fault_pkg::S_BLOCKED, close_onto_fault_pkg::S_ACTIVE,
            close_onto_fault_pkg::S_TRIP};
      inh <= 1'b1;
      for (int f = 1; f < 4; f++) begin
         wbx(1, close_onto_fault_pkg::A_CTRL, 32'h300 | (f << 4));
         wbx(0, close_onto_fault_pkg::A_STATUS, 0);
         chk("forced", e[f - 1], q[2:0]);
      end
      inh <= 1'b0;
      wbx(1, close_onto_fault_pkg::A_CTRL, 32'h300);
   endtask
   task automatic t_irq();
      int b;
      b = 1 << (2 * close_onto_fault_pkg::C_ACT);
      wbx(1, close_onto_fault_pkg::A_EV_STS, 32'hff);
      wbx(1, close_onto_fault_pkg::A_EV_MSK, b);
      wbx(1, close_onto_fault_pkg::A_TIME, 32'h100);
      repeat (2) @(posedge clk_i);
      chk("irq", 0, irq);
      pulse_arm();
      wait_on(open_w, 1'b1, 20);
      repeat (3) @(posedge clk_i);
      chk("irq", 1, irq);
      wbx(0, close_onto_fault_pkg::A_LAST_T, 0);
      chk("stamp", 1, q >= 32'h100 && q < 32'h108);
      wbx(1, close_onto_fault_pkg::A_EV_MSK, 0);
      repeat (2) @(posedge clk_i);
      chk("irq", 0, irq);
      wbx(1, close_onto_fault_pkg::A_EV_MSK, b);
      repeat (2) @(posedge clk_i);
      chk("irq", 1, irq);
      wbx(1, close_onto_fault_pkg::A_EV_STS, b);
      repeat (2) @(posedge clk_i);
      chk("irq", 0, irq);
      wait_on(open_w, 1'b0, 100);
   endtask
   task automatic t_log();
      int h;
      wbx(0, close_onto_fault_pkg::A_LOG_HEAD, 0);
      h = q[3:0];
      repeat (13) begin
         pulse_arm();
         repeat (6) @(posedge clk_i);
      end
      wait_on(open_w, 1'b0, 100);
      wbx(0, close_onto_fault_pkg::A_LOG_HEAD, 0);
      chk("log", 32'hc0 | ((h + 13) % 12), q & 32'hff);
      wbx(1, close_onto_fault_pkg::A_LOG_SEL, h);
      wbx(0, close_onto_fault_pkg::A_LOG_REM, 0);
      chk("log rem", 3, q);
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_window();
      t_level();
      t_restart();
      t_group();
      t_trip();
      t_block();
      t_modes();
      t_force();
      t_irq();
      t_log();
      stop_test();
   end
   // the whole run needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
